// [rtl/pef_flag_register.sv]
// pef_flag_register.sv: peripheral event flag register with enable mask,
// register port and one level interrupt.
// assumes: every event input is a one-cycle pulse or level from on-chip
// logic on clk; register master follows the plain strobe protocol.
`timescale 1ns/10ps
`include "pef_map.svh"

module pef_flag_register (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // register port
   input  wire logic [`PEF_ADDR_W-1:0]     addr,
   input  wire logic [`PEF_DATA_W-1:0]     wrData,
   input  wire logic                       wrEn,
   input  wire logic                       rdEn,
   output      logic [`PEF_DATA_W-1:0]     rdData,
   // parallel slave port and converter events
   input  wire logic                       pspAccess,
   input  wire logic                       adcDone,
   // serial receiver and transmitter buffer levels
   input  wire logic                       rxBufferFull,
   input  wire logic                       txBufferEmpty,
   // synchronous serial port
   input  wire pef_pkg::pef_ssp_mode_t     sspMode,
   input  wire logic                       sspByteDone,
   input  wire logic                       sspStartDone,
   input  wire logic                       sspRestartDone,
   input  wire logic                       sspAckDone,
   input  wire logic                       sspBusStart,
   input  wire logic                       sspIdle,
   // capture/compare unit one
   input  wire pef_pkg::pef_ccp_mode_t     ccpMode,
   input  wire logic                       ccpCapture,
   input  wire logic                       ccpMatch,
   // flag view and interrupt
   output      logic [`PEF_DATA_W-1:0]     flagsOut,
   output      logic                       irq
);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // write strobe aimed at one register
   function automatic logic hitWrite(
      input logic                   strobe,
      input logic [`PEF_ADDR_W-1:0] at,
      input logic [`PEF_ADDR_W-1:0] ofs
   );
      hitWrite = strobe && (at == ofs);
   endfunction : hitWrite

   // qualified serial port event for the current mode
   function automatic logic sspEvent(
      input pef_pkg::pef_ssp_mode_t mode,
      input logic                   byteDone,
      input logic                   startDone,
      input logic                   restartDone,
      input logic                   ackDone,
      input logic                   busStart,
      input logic                   idle
   );
      sspEvent = 1'b0;
      unique case (mode)
         pef_pkg::PEF_SSP_OFF: begin
            sspEvent = 1'b0;
         end
         pef_pkg::PEF_SSP_SPI,
         pef_pkg::PEF_SSP_I2C_SLAVE: begin
            sspEvent = byteDone;
         end
         pef_pkg::PEF_SSP_I2C_MASTER: begin
            // master byte, bus conditions and a foreign Start when idle
            sspEvent = byteDone
                     | startDone
                     | restartDone
                     | ackDone
                     | (busStart & idle);
         end
      endcase
   endfunction : sspEvent

   // qualified capture/compare event for the current mode
   function automatic logic ccpEvent(
      input pef_pkg::pef_ccp_mode_t mode,
      input logic                   capture,
      input logic                   match
   );
      ccpEvent = 1'b0;
      unique case (mode)
         pef_pkg::PEF_CCP_OFF: begin
            ccpEvent = 1'b0;
         end
         pef_pkg::PEF_CCP_CAPTURE: begin
            ccpEvent = capture;
         end
         pef_pkg::PEF_CCP_COMPARE: begin
            ccpEvent = match;
         end
         pef_pkg::PEF_CCP_PWM: begin
            ccpEvent = 1'b0;
         end
      endcase
   endfunction : ccpEvent

   // ****************************************************************
   // state
   // ****************************************************************

   pef_pkg::pef_top_state_t state_reg;
   pef_pkg::pef_top_state_t state_next;

   logic [`PEF_DATA_W-1:0]  setVec;
   logic [`PEF_DATA_W-1:0]  clearVec;
   logic [`PEF_DATA_W-1:0]  stickyFlags;
   logic [`PEF_DATA_W-1:0]  flagView;
   logic                    flagsWrite;
   logic                    enableWrite;

   // ****************************************************************
   // event collection
   // ****************************************************************

   // decode of the two writable registers
   assign flagsWrite  = hitWrite(wrEn, addr, `PEF_OFS_FLAGS);
   assign enableWrite = hitWrite(wrEn, addr, `PEF_OFS_ENABLE);

   // one set line per sticky bit; level bits never latch
   always_comb begin
      setVec = `PEF_ZERO8;
      setVec[`PEF_BIT_PSP] = pspAccess;
      setVec[`PEF_BIT_ADC] = adcDone;
      setVec[`PEF_BIT_SSP] = sspEvent(sspMode, sspByteDone, sspStartDone,
                                      sspRestartDone, sspAckDone,
                                      sspBusStart, sspIdle);
      setVec[`PEF_BIT_CCP] = ccpEvent(ccpMode, ccpCapture, ccpMatch);
   end

   // a one written to a sticky bit clears it; zero leaves it alone
   always_comb begin
      clearVec = `PEF_ZERO8;
      if (flagsWrite) begin
         clearVec = wrData & `PEF_STICKY_MASK;
      end
   end

   // latched flags; an event in the clear cycle survives
   pef_sticky_flags u_sticky (
      .clk      (clk),
      .rst      (rst),
      .setVec   (setVec),
      .clearVec (clearVec),
      .flags    (stickyFlags)
   );

   // ****************************************************************
   // flag view
   // ****************************************************************

   // sticky bits merged with the two buffer levels
   always_comb begin
      flagView = stickyFlags & `PEF_STICKY_MASK;
      flagView[`PEF_BIT_RX] = state_reg.rxFull;
      flagView[`PEF_BIT_TX] = state_reg.txEmpty;
   end

   // ****************************************************************
   // next state
   // ****************************************************************

   // buffer levels, enable mask, read data and interrupt
   always_comb begin
      state_next = state_reg;
      // buffer level bits follow the serial buffers; writes do not touch them
      state_next.rxFull  = rxBufferFull;
      state_next.txEmpty = txBufferEmpty;
      // enable mask only holds implemented bits
      if (enableWrite) begin
         state_next.enable = wrData & `PEF_IMPL_MASK;
      end
      // read data stands only in the cycle after the strobe
      state_next.rdData = `PEF_ZERO8;
      if (rdEn) begin
         if (addr == `PEF_OFS_FLAGS) begin
            state_next.rdData = flagView;
         end else if (addr == `PEF_OFS_ENABLE) begin
            state_next.rdData = state_reg.enable;
         end
      end
      // level interrupt while any enabled flag is set
      state_next.irq = |(flagView & state_reg.enable);
   end

   // register the state
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.enable  <= `PEF_ENABLE_RST;
         state_reg.rxFull  <= 1'b0;
         state_reg.txEmpty <= 1'b0;
         state_reg.rdData  <= `PEF_ZERO8;
         state_reg.irq     <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************

   // all outputs come from flip-flops
   assign rdData   = state_reg.rdData;
   assign irq      = state_reg.irq;
   assign flagsOut = flagView;

endmodule : pef_flag_register

// [rtl/pef_map.svh]
// pef_map.svh: offsets, bit positions, reset values and masks of the
// peripheral event flag block.
// assumes: included by bare name from the package and the design files.
`ifndef PEF_MAP_SVH
`define PEF_MAP_SVH

// ****************************************************************
// register bus
// ****************************************************************
`define PEF_ADDR_W        4
`define PEF_DATA_W        8
`define PEF_OFS_FLAGS     4'h0
`define PEF_OFS_ENABLE    4'h1

// ****************************************************************
// flag bit positions
// ****************************************************************
`define PEF_BIT_PSP       7
`define PEF_BIT_ADC       6
`define PEF_BIT_RX        5
`define PEF_BIT_TX        4
`define PEF_BIT_SSP       3
`define PEF_BIT_CCP       2

// ****************************************************************
// reset values and masks
// ****************************************************************
`define PEF_FLAGS_RST     8'h00
`define PEF_ENABLE_RST    8'h00
`define PEF_ZERO8         8'h00
`define PEF_STICKY_MASK   8'hCC
`define PEF_LEVEL_MASK    8'h30
`define PEF_IMPL_MASK     8'hFC

`endif

// [rtl/pef_pkg.sv]
// pef_pkg.sv: types shared by the peripheral event flag block.
// assumes: pef_map.svh sits in the include path.
`include "pef_map.svh"

package pef_pkg;

   // ****************************************************************
   // peripheral modes
   // ****************************************************************
   // operating mode of the synchronous serial port
   typedef enum logic [1:0] {
      PEF_SSP_OFF,
      PEF_SSP_SPI,
      PEF_SSP_I2C_SLAVE,
      PEF_SSP_I2C_MASTER
   } pef_ssp_mode_t;

   // operating mode of capture/compare unit one
   typedef enum logic [1:0] {
      PEF_CCP_OFF,
      PEF_CCP_CAPTURE,
      PEF_CCP_COMPARE,
      PEF_CCP_PWM
   } pef_ccp_mode_t;

   // ****************************************************************
   // module state
   // ****************************************************************
   // state of the sticky flag store
   typedef struct packed {
      logic [`PEF_DATA_W-1:0] flags;
   } pef_sticky_state_t;

   // state of the top block
   typedef struct packed {
      logic [`PEF_DATA_W-1:0] enable;
      logic                   rxFull;
      logic                   txEmpty;
      logic [`PEF_DATA_W-1:0] rdData;
      logic                   irq;
   } pef_top_state_t;

endpackage : pef_pkg

// [rtl/pef_sticky_flags.sv]
// pef_sticky_flags.sv: the latched event flags, one per sticky bit.
// assumes: set and clear vectors come from logic on the same clock.
`timescale 1ns/10ps
`include "pef_map.svh"

module pef_sticky_flags (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // per bit event and clear request
   input  wire logic [`PEF_DATA_W-1:0] setVec,
   input  wire logic [`PEF_DATA_W-1:0] clearVec,
   // latched flags
   output      logic [`PEF_DATA_W-1:0] flags
);

   pef_pkg::pef_sticky_state_t state_reg;
   pef_pkg::pef_sticky_state_t state_next;

   // set wins over a clear in the same cycle; only sticky bits exist
   always_comb begin
      state_next = state_reg;
      state_next.flags = ((state_reg.flags & ~clearVec) | setVec) & `PEF_STICKY_MASK;
   end

   // register the state
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.flags <= `PEF_FLAGS_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign flags = state_reg.flags;

endmodule : pef_sticky_flags

// [tb/pef_flag_chk.sv]
// pef_flag_chk.sv: port assertions of the peripheral event flag register.
// assumes: bound to pef_flag_register; one clock, synchronous reset.
`timescale 1ns/10ps
`include "pef_map.svh"

module pef_flag_chk (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   rst,
   // register port
   input wire logic [`PEF_ADDR_W-1:0] addr,
   input wire logic [`PEF_DATA_W-1:0] wrData,
   input wire logic                   wrEn,
   // events and levels
   input wire logic                   pspAccess,
   input wire logic                   adcDone,
   input wire logic                   rxBufferFull,
   input wire logic                   txBufferEmpty,
   input wire pef_pkg::pef_ssp_mode_t sspMode,
   input wire logic                   sspByteDone,
   input wire logic                   sspStartDone,
   input wire logic                   sspRestartDone,
   input wire logic                   sspAckDone,
   input wire logic                   sspBusStart,
   input wire logic                   sspIdle,
   input wire pef_pkg::pef_ccp_mode_t ccpMode,
   input wire logic                   ccpCapture,
   input wire logic                   ccpMatch,
   // flag view
   input wire logic [`PEF_DATA_W-1:0] flagsOut
);
   logic [`PEF_DATA_W-1:0] clrMask;
   logic [`PEF_DATA_W-1:0] hold;

   // ********************************
   // helpers
   // ********************************
   // sticky bits that no clear asks to drop this cycle
   assign clrMask = (wrEn && addr == `PEF_OFS_FLAGS) ? wrData : `PEF_ZERO8;
   assign hold    = flagsOut & ~clrMask & `PEF_STICKY_MASK;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // serial byte finished in SPI or I2C slave mode
   sequence sByteEvt;
      sspMode inside {pef_pkg::PEF_SSP_SPI, pef_pkg::PEF_SSP_I2C_SLAVE} && sspByteDone;
   endsequence
   // master sequence done, or bus start seen while idle
   sequence sMasterEvt;
      sspMode == pef_pkg::PEF_SSP_I2C_MASTER &&
      (sspStartDone || sspRestartDone || sspAckDone || (sspBusStart && sspIdle));
   endsequence

   // ********************************
   // assertions
   // ********************************
   AST_PSP_SET: assert property (pspAccess |=> flagsOut[7])
      else $error("parallel port flag not set");
   AST_ADC_SET: assert property (adcDone |=> flagsOut[6])
      else $error("conversion flag not set");
   AST_LEVELS: assert property (
      !$past(rst) |-> flagsOut[5:4] == {$past(rxBufferFull), $past(txBufferEmpty)})
      else $error("buffer level bits do not follow inputs");
   AST_STICKY: assert property (|hold |=> (flagsOut & $past(hold)) == $past(hold))
      else $error("sticky flag dropped without clear");
   AST_SSP_BYTE: assert property (sByteEvt |=> flagsOut[3])
      else $error("serial flag not set on byte");
   AST_SSP_MASTER: assert property (sMasterEvt |=> flagsOut[3])
      else $error("serial flag not set on master event");
   AST_CCP_SET: assert property (
      (ccpMode == pef_pkg::PEF_CCP_CAPTURE && ccpCapture) ||
      (ccpMode == pef_pkg::PEF_CCP_COMPARE && ccpMatch) |=> flagsOut[2])
      else $error("capture/compare flag not set");
   AST_PWM_QUIET: assert property (
      ccpMode == pef_pkg::PEF_CCP_PWM && !flagsOut[2] |=> !flagsOut[2])
      else $error("capture/compare flag set in PWM mode");

endmodule : pef_flag_chk

bind pef_flag_register pef_flag_chk i_chk (.*);

// [tb/testbench.sv]
// testbench.sv: register-level tests of the peripheral event flag register.
// assumes: pef_pkg, pef_map.svh and the checker are compiled beforehand.
`timescale 1ns/10ps
`include "pef_map.svh"

module testbench;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic [`PEF_ADDR_W-1:0] addr = 4'h0;
   logic [`PEF_DATA_W-1:0] wrData = 8'h00;
   logic                   wrEn = 1'b0;
   logic                   rdEn = 1'b0;
   logic [`PEF_DATA_W-1:0] rdData;
   logic [`PEF_DATA_W-1:0] flagsOut;
   logic                   irq;
   logic                   rxFull = 1'b0;
   logic                   txEmpty = 1'b0;
   logic                   sspIdle = 1'b1;
   logic [8:0]             pulse = 9'h000;
   pef_pkg::pef_ssp_mode_t sspMode = pef_pkg::PEF_SSP_OFF;
   pef_pkg::pef_ccp_mode_t ccpMode = pef_pkg::PEF_CCP_OFF;
   int                     errTotal = 0;
   int                     checkCount = 0;
   // event table: {serial mode, ccp mode}, pulse vector, expected sticky bits
   localparam logic [3:0] MD [15] = '{4'h0, 4'h0, 4'h4, 4'h8, 4'hC, 4'hC, 4'hC, 4'hC,
                                     4'h1, 4'h2, 4'h3, 4'hC, 4'h4, 4'h2, 4'h1};
   localparam logic [8:0] PL [15] = '{9'h100, 9'h080, 9'h040, 9'h040, 9'h020, 9'h010,
                                     9'h008, 9'h004, 9'h002, 9'h001, 9'h003, 9'h040,
                                     9'h03C, 9'h002, 9'h001};
   localparam logic [7:0] EX [15] = '{8'h80, 8'h40, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08,
                                     8'h08, 8'h04, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00,
                                     8'h00};

   // ********************************
   // device
   // ********************************
   pef_flag_register i_dut (
      .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
      .rdData(rdData), .pspAccess(pulse[8]), .adcDone(pulse[7]), .rxBufferFull(rxFull),
      .txBufferEmpty(txEmpty), .sspMode(sspMode), .sspByteDone(pulse[6]),
      .sspStartDone(pulse[5]), .sspRestartDone(pulse[4]), .sspAckDone(pulse[3]),
      .sspBusStart(pulse[2]), .sspIdle(sspIdle), .ccpMode(ccpMode), .ccpCapture(pulse[1]),
      .ccpMatch(pulse[0]), .flagsOut(flagsOut), .irq(irq));

   // 50 ns clock
   always #25 clk = ~clk;

   // ********************************
   // tasks
   // ********************************
   task automatic chk(input string name, input logic [7:0] expv, input logic [7:0] got);
      checkCount++;
      if (got !== expv) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", name, expv, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wrEn <= 1'b1;
      addr <= a;
      wrData <= d;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rdEn <= 1'b1;
      addr <= a;
      @(posedge clk);
      rdEn <= 1'b0;
      #1 chk("rdData", e, rdData);
   endtask : rd

   task automatic ev(input logic [8:0] v);
      @(posedge clk);
      pulse <= v;
      @(posedge clk);
      pulse <= 9'h000;
   endtask : ev

   // irq follows flags and enable one edge late
   task automatic irqIs(input logic e);
      repeat (2) @(posedge clk);
      #1 chk("irq", {7'h00, e}, {7'h00, irq});
   endtask : irqIs

   task automatic test_done;
      if (errTotal == 0 && checkCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   // ********************************
   // tests
   // ********************************
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(`PEF_OFS_FLAGS, 8'h00);
      rd(`PEF_OFS_ENABLE, 8'h00);
      rd(4'hF, 8'h00);
      @(posedge clk);
      rxFull <= 1'b1;
      txEmpty <= 1'b1;
      rd(`PEF_OFS_FLAGS, 8'h30);
      wr(`PEF_OFS_FLAGS, 8'hFF);
      rd(`PEF_OFS_FLAGS, 8'h30);
      @(posedge clk);
      rxFull <= 1'b0;
      rd(`PEF_OFS_FLAGS, 8'h10);
      for (int i = 0; i < 15; i++) begin
         @(posedge clk);
         sspMode <= pef_pkg::pef_ssp_mode_t'(MD[i][3:2]);
         ccpMode <= pef_pkg::pef_ccp_mode_t'(MD[i][1:0]);
         ev(PL[i]);
         #1 chk("flagsOut", EX[i] | 8'h10, flagsOut);
         rd(`PEF_OFS_FLAGS, EX[i] | 8'h10);
         wr(`PEF_OFS_FLAGS, 8'hCC);
         rd(`PEF_OFS_FLAGS, 8'h10);
      end
      wr(`PEF_OFS_ENABLE, 8'hFF);
      rd(`PEF_OFS_ENABLE, 8'hFC);
      irqIs(1'b1);
      wr(`PEF_OFS_ENABLE, 8'h00);
      irqIs(1'b0);
      ev(9'h080);
      irqIs(1'b0);
      wr(`PEF_OFS_ENABLE, 8'h40);
      irqIs(1'b1);
      wr(`PEF_OFS_FLAGS, 8'h40);
      irqIs(1'b0);
      // clear and conversion event in one cycle: the event wins
      @(posedge clk);
      wrEn <= 1'b1;
      addr <= `PEF_OFS_FLAGS;
      wrData <= 8'h40;
      pulse <= 9'h080;
      @(posedge clk);
      wrEn <= 1'b0;
      pulse <= 9'h000;
      rd(`PEF_OFS_FLAGS, 8'h50);
      irqIs(1'b1);
      // foreign Start while the serial port is busy is ignored
      @(posedge clk);
      sspMode <= pef_pkg::PEF_SSP_I2C_MASTER;
      sspIdle <= 1'b0;
      ev(9'h004);
      rd(`PEF_OFS_FLAGS, 8'h50);
      // reset in mid-run drops latched flags and the mask
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(`PEF_OFS_FLAGS, 8'h10);
      rd(`PEF_OFS_ENABLE, 8'h00);
      irqIs(1'b0);
      test_done;
   end

   // watchdog against a hang
   initial begin
      repeat (4000) @(posedge clk);
      errTotal++;
      test_done;
   end

endmodule : testbench
